// ==== pkg/msc_regs.vh ====
// register map and timing constants of the motion sensor control block
// assumes: included by design files, definitions only
`ifndef MSC_REGS_VH
`define MSC_REGS_VH

// ==========================================================
// offsets
`define MSC_ADDR_ORIENT_PREV     8'h11
`define MSC_ADDR_TAP_DIR_SRC     8'h15
`define MSC_ADDR_FUNC_EVT_SRC    8'h16
`define MSC_ADDR_IRQ_STATUS      8'h18
`define MSC_ADDR_IRQ_RELEASE     8'h1a
`define MSC_ADDR_MAIN_CTRL       8'h1b
`define MSC_ADDR_ORIENT_IRQ_EN   8'h1c
`define MSC_ADDR_RATE_CTRL       8'h1d
`define MSC_ADDR_PIN_CTRL        8'h1e
`define MSC_ADDR_SELFTEST_RESP   8'h0c
`define MSC_ADDR_ACCEL_FIRST     8'h06
`define MSC_ADDR_ACCEL_LAST      8'h0b

// ==========================================================
// reset values
`define MSC_RST_ORIENT_PREV      8'h20
`define MSC_RST_MAIN_CTRL        8'h00
`define MSC_RST_RATE_CTRL        8'h4d
`define MSC_RST_ORIENT_IRQ_EN    8'h3f
`define MSC_RST_PIN_CTRL         8'h10
`define MSC_SELFTEST_IDLE        8'h55
`define MSC_SELFTEST_ACTIVE      8'haa
`define MSC_ZERO8                8'h00

// ==========================================================
// field positions
`define MSC_MC_OPERATE           7
`define MSC_MC_RES               6
`define MSC_MC_NEW_SAMPLE_EN     5
`define MSC_MC_RANGE_HI          4
`define MSC_MC_RANGE_LO          3
`define MSC_MC_TAP_EN            2
`define MSC_MC_MOTION_EN         1
`define MSC_MC_ORIENT_EN         0
`define MSC_RC_REBOOT            7
`define MSC_RC_ORIENT_HI         6
`define MSC_RC_ORIENT_LO         5
`define MSC_RC_SELFTEST          4
`define MSC_RC_TAP_HI            3
`define MSC_RC_TAP_LO            2
`define MSC_RC_MOTION_HI         1
`define MSC_RC_MOTION_LO         0
`define MSC_PC_PIN_EN            5
`define MSC_PC_PIN_POL           4
`define MSC_PC_PULSE             3
`define MSC_PC_UNLATCHED         2
`define MSC_FS_NEW_SAMPLE        4
`define MSC_ST_IRQ               4
`define MSC_TAP_SINGLE           2'b01
`define MSC_TAP_DOUBLE           2'b10
`define MSC_TAP_NONE             2'b00

// ==========================================================
// timing: pulse 0.05 ms = 50000 ns, clock 4 ns
`define MSC_PULSE_NS             50000
`define MSC_CLK_NS               4
`define MSC_REBOOT_CYCLES        16'h0100
// rate dividers: period of a 1 MHz tick base, in clock cycles
`define MSC_TICK_CYCLES          8'hfa

`endif

// ==== src/msc_ctrl_irq_regs.v ====
// control, event-source and status registers of a three-axis motion sensor
// assumes: an i2c front end on the same clock gives one-cycle read/write strobes;
// detector strobes are one-cycle pulses and motion_active is a level, all from logic on the same clock.
`timescale 1ns/1ps
`include "msc_regs.vh"
module msc_ctrl_irq_regs (
    clk,
    resetn,
    reg_addr,
    reg_wr,
    reg_rd,
    reg_wdata,
    reg_rdata,
    orient_new,
    orient_new_valid,
    tap_dir,
    tap_double,
    tap_valid,
    motion_valid,
    motion_active,
    sample_ready,
    operate,
    high_res,
    range_sel,
    tap_run,
    motion_run,
    orient_run,
    orient_rate_en,
    tap_rate_en,
    motion_rate_en,
    reboot_busy,
    irq_out
);
    input wire clk;
    input wire resetn;
    input wire [7:0] reg_addr;
    input wire reg_wr;
    input wire reg_rd;
    input wire [7:0] reg_wdata;
    output reg [7:0] reg_rdata;
    input wire [5:0] orient_new;
    input wire orient_new_valid;
    input wire [5:0] tap_dir;
    input wire tap_double;
    input wire tap_valid;
    input wire motion_valid;
    input wire motion_active;
    input wire sample_ready;
    output wire operate;
    output wire high_res;
    output wire [1:0] range_sel;
    output wire tap_run;
    output wire motion_run;
    output wire orient_run;
    output wire orient_rate_en;
    output wire tap_rate_en;
    output wire motion_rate_en;
    output wire reboot_busy;
    output reg irq_out;

    localparam [15:0] PULSE_CYCLES = (`MSC_PULSE_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS;
    localparam [7:0] ORIENT_RST = `MSC_RST_ORIENT_PREV;

    reg [7:0] main_control_reg;
    reg [7:0] rate_ctrl_reg;
    reg [7:0] orient_irq_en_reg;
    reg [7:0] pin_ctrl_reg;
    reg [5:0] orient_cur_reg;
    reg [5:0] orient_prev_reg;
    reg [5:0] tap_src_reg;
    reg [1:0] tap_kind_reg;
    reg motion_flag_reg;
    reg orient_flag_reg;
    reg sample_flag_reg;
    reg irq_reg;
    reg [15:0] reboot_cnt_reg;
    reg [15:0] pulse_cnt_reg;
    reg [7:0] tick_cnt_reg;
    reg tick_en_reg;

    wire rd_release;
    wire rd_accel;
    wire rd_selftest;
    wire motion_flag;
    wire orient_event;
    wire tap_event;
    wire motion_event;
    wire any_event;
    wire [5:0] orient_changed;
    wire irq_next;

    // ==========================================================
    // address decode helper
    function is_addr;
        input [7:0] a;
        input [7:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    function [19:0] period4;
        input [1:0] code;
        input [19:0] p0;
        input [19:0] p1;
        input [19:0] p2;
        input [19:0] p3;
        begin
            if (code == 2'b00) begin
                period4 = p0;
            end else if (code == 2'b01) begin
                period4 = p1;
            end else if (code == 2'b10) begin
                period4 = p2;
            end else begin
                period4 = p3;
            end
        end
    endfunction

    assign rd_release = reg_rd && is_addr(reg_addr, `MSC_ADDR_IRQ_RELEASE);
    assign rd_selftest = reg_rd && is_addr(reg_addr, `MSC_ADDR_SELFTEST_RESP);
    assign rd_accel = reg_rd && (reg_addr >= `MSC_ADDR_ACCEL_FIRST) &&
        (reg_addr <= `MSC_ADDR_ACCEL_LAST);

    // ==========================================================
    // control outputs
    assign operate = main_control_reg[`MSC_MC_OPERATE];
    assign high_res = main_control_reg[`MSC_MC_RES];
    // code 11 is passed on; the range detector treats it as unused
    assign range_sel = {main_control_reg[`MSC_MC_RANGE_HI],
        main_control_reg[`MSC_MC_RANGE_LO]};
    assign tap_run = operate && main_control_reg[`MSC_MC_TAP_EN];
    assign motion_run = operate && main_control_reg[`MSC_MC_MOTION_EN];
    assign orient_run = operate && main_control_reg[`MSC_MC_ORIENT_EN];
    assign reboot_busy = rate_ctrl_reg[`MSC_RC_REBOOT];

    // ==========================================================
    // 1 MHz tick base and rate generators
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_reg <= `MSC_ZERO8;
            tick_en_reg <= 1'b0;
        end else if (tick_cnt_reg == `MSC_TICK_CYCLES - 8'h01) begin
            tick_cnt_reg <= `MSC_ZERO8;
            tick_en_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 8'h01;
            tick_en_reg <= 1'b0;
        end
    end

    msc_rate_gen u_orient_rate (
        .clk(clk),
        .resetn(resetn),
        .tick_en(tick_en_reg),
        .run(orient_run),
        .period_us(period4(rate_ctrl_reg[6:5], 20'd625000, 20'd158730,
            20'd80000, 20'd20000)),
        .rate_en(orient_rate_en)
    );

    msc_rate_gen u_tap_rate (
        .clk(clk),
        .resetn(resetn),
        .tick_en(tick_en_reg),
        .run(tap_run),
        .period_us(period4(rate_ctrl_reg[3:2], 20'd20000, 20'd10000,
            20'd5000, 20'd2500)),
        .rate_en(tap_rate_en)
    );

    msc_rate_gen u_motion_rate (
        .clk(clk),
        .resetn(resetn),
        .tick_en(tick_en_reg),
        .run(motion_run),
        .period_us(period4(rate_ctrl_reg[1:0], 20'd40000, 20'd20000,
            20'd10000, 20'd5000)),
        .rate_en(motion_rate_en)
    );

    // ==========================================================
    // register writes, reboot and self-test
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            main_control_reg <= `MSC_RST_MAIN_CTRL;
            rate_ctrl_reg <= `MSC_RST_RATE_CTRL;
            orient_irq_en_reg <= `MSC_RST_ORIENT_IRQ_EN;
            pin_ctrl_reg <= `MSC_RST_PIN_CTRL;
            reboot_cnt_reg <= 16'h0000;
        end else if (rate_ctrl_reg[`MSC_RC_REBOOT]) begin
            // reboot restores defaults, bit stays 1 until done
            if (reboot_cnt_reg == `MSC_REBOOT_CYCLES) begin
                reboot_cnt_reg <= 16'h0000;
                main_control_reg <= `MSC_RST_MAIN_CTRL;
                rate_ctrl_reg <= `MSC_RST_RATE_CTRL;
                orient_irq_en_reg <= `MSC_RST_ORIENT_IRQ_EN;
                pin_ctrl_reg <= `MSC_RST_PIN_CTRL;
            end else begin
                reboot_cnt_reg <= reboot_cnt_reg + 16'h0001;
            end
        end else if (reg_wr) begin
            // settings writes rely on host being in standby
            if (is_addr(reg_addr, `MSC_ADDR_MAIN_CTRL)) begin
                main_control_reg <= reg_wdata;
            end else if (is_addr(reg_addr, `MSC_ADDR_RATE_CTRL)) begin
                rate_ctrl_reg <= reg_wdata;
            end else if (is_addr(reg_addr, `MSC_ADDR_ORIENT_IRQ_EN)) begin
                orient_irq_en_reg <= {2'b00, reg_wdata[5:0]};
            end else if (is_addr(reg_addr, `MSC_ADDR_PIN_CTRL)) begin
                pin_ctrl_reg <= {2'b00, reg_wdata[5:2], 2'b00};
            end
        end else if (rd_selftest) begin
            rate_ctrl_reg[`MSC_RC_SELFTEST] <= 1'b0;
        end
    end

    // ==========================================================
    // orientation tracking
    assign orient_changed = orient_new & ~orient_cur_reg;
    assign orient_event = orient_run && orient_new_valid && (orient_new != orient_cur_reg) &&
        |(orient_changed & orient_irq_en_reg[5:0]);
    assign tap_event = tap_run && tap_valid;
    assign motion_event = motion_run && motion_valid;
    // unlatched motion follows the detector level
    assign motion_flag = pin_ctrl_reg[`MSC_PC_UNLATCHED] ? (motion_run && motion_active) :
        motion_flag_reg;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            orient_cur_reg <= ORIENT_RST[5:0];
            orient_prev_reg <= ORIENT_RST[5:0];
        end else if (orient_run && orient_new_valid && (orient_new != orient_cur_reg)) begin
            orient_prev_reg <= orient_cur_reg;
            orient_cur_reg <= orient_new;
        end
    end

    // ==========================================================
    // event latches; a new event in a release cycle wins
    assign any_event = orient_event || tap_event || motion_event ||
        (sample_ready && main_control_reg[`MSC_MC_NEW_SAMPLE_EN]);
    // in level mode the pin follows the status bit's next value so both clear on one edge
    assign irq_next = any_event || (irq_reg && !rd_release);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tap_src_reg <= 6'h00;
            tap_kind_reg <= `MSC_TAP_NONE;
            motion_flag_reg <= 1'b0;
            orient_flag_reg <= 1'b0;
            sample_flag_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            if (tap_event) begin
                tap_src_reg <= tap_dir;
                tap_kind_reg <= tap_double ? `MSC_TAP_DOUBLE : `MSC_TAP_SINGLE;
            end else if (rd_release) begin
                tap_src_reg <= 6'h00;
                tap_kind_reg <= `MSC_TAP_NONE;
            end
            if (motion_event) begin
                motion_flag_reg <= 1'b1;
            end else if (rd_release) begin
                motion_flag_reg <= 1'b0;
            end
            if (orient_event) begin
                orient_flag_reg <= 1'b1;
            end else if (rd_release) begin
                orient_flag_reg <= 1'b0;
            end
            if (sample_ready && operate) begin
                sample_flag_reg <= 1'b1;
            end else if (rd_release || rd_accel) begin
                sample_flag_reg <= 1'b0;
            end
            if (any_event) begin
                irq_reg <= 1'b1;
            end else if (rd_release) begin
                irq_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // interrupt pin: latched level or one 0.05 ms pulse
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulse_cnt_reg <= 16'h0000;
            irq_out <= 1'b0;
        end else begin
            if (any_event && pin_ctrl_reg[`MSC_PC_PULSE]) begin
                pulse_cnt_reg <= PULSE_CYCLES;
            end else if (pulse_cnt_reg != 16'h0000) begin
                pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
            end
            if (!pin_ctrl_reg[`MSC_PC_PIN_EN]) begin
                irq_out <= ~pin_ctrl_reg[`MSC_PC_PIN_POL];
            end else if (pin_ctrl_reg[`MSC_PC_PULSE]) begin
                irq_out <= (pulse_cnt_reg != 16'h0000) ~^ pin_ctrl_reg[`MSC_PC_PIN_POL];
            end else begin
                irq_out <= (irq_next || (pin_ctrl_reg[`MSC_PC_UNLATCHED] && motion_flag)) ~^
                    pin_ctrl_reg[`MSC_PC_PIN_POL];
            end
        end
    end

    // ==========================================================
    // read data; unmapped addresses read zero
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= `MSC_ZERO8;
        end else if (reg_rd) begin
            if (is_addr(reg_addr, `MSC_ADDR_ORIENT_PREV)) begin
                reg_rdata <= {2'b00, orient_prev_reg};
            end else if (is_addr(reg_addr, `MSC_ADDR_TAP_DIR_SRC)) begin
                reg_rdata <= {2'b00, tap_src_reg};
            end else if (is_addr(reg_addr, `MSC_ADDR_FUNC_EVT_SRC)) begin
                reg_rdata <= {3'b000, sample_flag_reg, tap_kind_reg, motion_flag,
                    orient_flag_reg};
            end else if (is_addr(reg_addr, `MSC_ADDR_IRQ_STATUS)) begin
                reg_rdata <= {3'b000, irq_reg, 4'h0};
            end else if (is_addr(reg_addr, `MSC_ADDR_MAIN_CTRL)) begin
                reg_rdata <= main_control_reg;
            end else if (is_addr(reg_addr, `MSC_ADDR_ORIENT_IRQ_EN)) begin
                reg_rdata <= orient_irq_en_reg;
            end else if (is_addr(reg_addr, `MSC_ADDR_RATE_CTRL)) begin
                reg_rdata <= rate_ctrl_reg;
            end else if (is_addr(reg_addr, `MSC_ADDR_PIN_CTRL)) begin
                reg_rdata <= pin_ctrl_reg;
            end else if (is_addr(reg_addr, `MSC_ADDR_SELFTEST_RESP)) begin
                reg_rdata <= rate_ctrl_reg[`MSC_RC_SELFTEST] ? `MSC_SELFTEST_ACTIVE :
                    `MSC_SELFTEST_IDLE;
            end else begin
                reg_rdata <= `MSC_ZERO8;
            end
        end
    end
endmodule

// ==== src/msc_rate_gen.v ====
// rate enable generator: one-cycle pulse at a selectable rate
// assumes: tick_en is a 1 MHz enable pulse from the same clock
`timescale 1ns/1ps
module msc_rate_gen (
    clk,
    resetn,
    tick_en,
    run,
    period_us,
    rate_en
);
    input wire clk;
    input wire resetn;
    input wire tick_en;
    input wire run;
    input wire [19:0] period_us;
    output reg rate_en;

    reg [19:0] cnt_reg;

    // ==========================================================
    // divider; held clear in standby so rates restart cleanly
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 20'h00000;
            rate_en <= 1'b0;
        end else if (!run) begin
            cnt_reg <= 20'h00000;
            rate_en <= 1'b0;
        end else begin
            rate_en <= 1'b0;
            if (tick_en) begin
                if (cnt_reg >= period_us - 20'h00001) begin
                    cnt_reg <= 20'h00000;
                    rate_en <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 20'h00001;
                end
            end
        end
    end
endmodule

// ==== tb/msc_ctrl_irq_regs_props.sv ====
// concurrent checks on the control and event register block
// assumes: bound to msc_ctrl_irq_regs, single clock domain, async active-low reset
`timescale 1ns/1ps
module msc_ctrl_irq_regs_chk (
    input wire clk,
    input wire resetn,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire operate,
    input wire high_res,
    input wire [1:0] range_sel,
    input wire tap_run,
    input wire motion_run,
    input wire orient_run,
    input wire reboot_busy,
    input wire orient_rate_en,
    input wire tap_rate_en,
    input wire motion_rate_en
);
    // ==========================================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_RDATA_HOLD: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_RELEASE_READ_ZERO: assert property (
        reg_rd && !reg_wr && reg_addr == 8'h1a |=> reg_rdata == 8'h00)
        else $error("release read returned nonzero");
    AST_SELFTEST_VALUE: assert property (
        reg_rd && !reg_wr && reg_addr == 8'h0c |=> reg_rdata inside {8'h55, 8'haa})
        else $error("self-test response out of range");
    AST_RUN_NEEDS_OPERATE: assert property (
        tap_run || motion_run || orient_run |-> operate)
        else $error("detector running in standby");
    AST_OPERATE_WRITE: assert property (
        reg_wr && reg_addr == 8'h1b && !reboot_busy |=> operate == $past(reg_wdata[7]))
        else $error("operate bit not taken from write");
    AST_RES_WRITE: assert property (
        reg_wr && reg_addr == 8'h1b && !reboot_busy |=> high_res == $past(reg_wdata[6]))
        else $error("resolution bit not taken from write");
    AST_RANGE_WRITE: assert property (
        reg_wr && reg_addr == 8'h1b && !reboot_busy |=> range_sel == $past(reg_wdata[4:3]))
        else $error("range field not taken from write");
    AST_REBOOT_START: assert property (
        reg_wr && reg_addr == 8'h1d && reg_wdata[7] && !reboot_busy |=> reboot_busy)
        else $error("reboot did not start");
    AST_REBOOT_LENGTH: assert property (
        $rose(reboot_busy) |-> reboot_busy[*8] ##[1:300] !reboot_busy)
        else $error("reboot too short or never ends");
    // rates are far too slow to time here; only their silence with all three functions stopped is checked
    AST_RATE_IDLE_STOPPED: assert property (
        !orient_run && !tap_run && !motion_run |=>
        !(orient_rate_en || tap_rate_en || motion_rate_en))
        else $error("rate enable pulsed while its function is stopped");
endmodule

bind msc_ctrl_irq_regs msc_ctrl_irq_regs_chk u_chk (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .operate(operate), .high_res(high_res),
    .range_sel(range_sel), .tap_run(tap_run), .motion_run(motion_run),
    .orient_run(orient_run), .reboot_busy(reboot_busy), .orient_rate_en(orient_rate_en),
    .tap_rate_en(tap_rate_en), .motion_rate_en(motion_rate_en));

// ==== tb/msc_host_model.sv ====
// host side of the register port: one-cycle read and write strobes
// assumes: strobes launched at the falling edge, taken at the next rising edge
`timescale 1ns/1ps
module msc_host_model (
    input wire clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // ==========================================================
    // bus cycles
    // callers change settings only with operate clear
    task wr(input [7:0] a, input [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        // unqualified lines toggle so stale values never look valid
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task rd(input [7:0] a, output [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        d = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
endmodule

// ==== tb/test_msc_ctrl_irq_regs.sv ====
// self-checking bench for the control and event register block
// assumes: host model drives the register port, bench drives detector pulses
`timescale 1ns/1ps
module test_msc_ctrl_irq_regs;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire reg_wr, reg_rd, operate, high_res, tap_run, motion_run, orient_run;
    wire reboot_busy, irq_out;
    wire [1:0] range_sel;
    reg [5:0] orient_new = 6'h00;
    reg [5:0] tap_dir = 6'h00;
    reg orient_new_valid = 1'b0;
    reg tap_double = 1'b0;
    reg tap_valid = 1'b0;
    reg motion_valid = 1'b0;
    reg motion_active = 1'b0;
    reg sample_ready = 1'b0;
    integer n_mismatch = 0;
    integer n_tests = 0;
    integer cyc = 0;
    integer i;
    reg [7:0] v;

    always #2 clk = ~clk;

    msc_host_model u_msc_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    msc_ctrl_irq_regs u_msc_ctrl_irq_regs (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .orient_new(orient_new), .orient_new_valid(orient_new_valid), .tap_dir(tap_dir),
        .tap_double(tap_double), .tap_valid(tap_valid), .motion_valid(motion_valid),
        .motion_active(motion_active), .sample_ready(sample_ready), .operate(operate),
        .high_res(high_res), .range_sel(range_sel), .tap_run(tap_run),
        .motion_run(motion_run), .orient_run(orient_run), .orient_rate_en(),
        .tap_rate_en(), .motion_rate_en(), .reboot_busy(reboot_busy), .irq_out(irq_out));

    // ==========================================================
    // helpers
    task chk(input [7:0] seen, input [7:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task rc(input [7:0] a, input [7:0] exp);
        u_msc_host_model.rd(a, v);
        chk(v, exp);
    endtask
    // sel bits: orientation, tap, motion, new sample
    task pulse(input [3:0] sel);
        @(negedge clk);
        {orient_new_valid, tap_valid, motion_valid, sample_ready} = sel;
        @(negedge clk);
        {orient_new_valid, tap_valid, motion_valid, sample_ready} = 4'h0;
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // hang guard, run is about 130 cycles plus reboot and one 12500-cycle pulse
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish;
        end
    end

    // ==========================================================
    // tests
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk) resetn = 1'b1;
        rc(8'h11, 8'h20);
        rc(8'h1b, 8'h00);
        rc(8'h1d, 8'h4d);
        rc(8'h0c, 8'h55);
        rc(8'h30, 8'h00);
        $display("reset values done");
        for (i = 0; i < 3; i = i + 1) begin
            u_msc_host_model.wr(8'h1b, {3'h0, i[1:0], 3'h0});
            chk({6'h0, range_sel}, {6'h0, i[1:0]});
        end
        u_msc_host_model.wr(8'h1e, 8'h30);
        u_msc_host_model.wr(8'h1b, 8'h67);
        chk({7'h0, operate}, 8'h00);
        u_msc_host_model.wr(8'h1b, 8'he7);
        chk({operate, high_res, range_sel, tap_run, motion_run, orient_run, 1'b0}, 8'hce);
        $display("control fields done");
        pulse(4'b0001);
        rc(8'h16, 8'h10);
        u_msc_host_model.rd(8'h06, v);
        rc(8'h16, 8'h00);
        tap_dir = 6'b100000;
        pulse(4'b0100);
        rc(8'h15, 8'h20);
        rc(8'h16, 8'h04);
        u_msc_host_model.rd(8'h18, v);
        chk({7'h0, v[4]}, 8'h01);
        chk({7'h0, irq_out}, 8'h01);
        rc(8'h1a, 8'h00);
        chk({7'h0, irq_out}, 8'h00);
        rc(8'h15, 8'h00);
        rc(8'h16, 8'h00);
        u_msc_host_model.rd(8'h18, v);
        chk({7'h0, v[4]}, 8'h00);
        tap_double = 1'b1;
        tap_dir = 6'b000001;
        pulse(4'b0100);
        pulse(4'b0010);
        rc(8'h15, 8'h01);
        rc(8'h16, 8'h0a);
        rc(8'h16, 8'h0a);
        rc(8'h1a, 8'h00);
        orient_new = 6'b010000;
        pulse(4'b1000);
        rc(8'h16, 8'h01);
        rc(8'h1a, 8'h00);
        rc(8'h16, 8'h00);
        $display("event latching done");
        u_msc_host_model.wr(8'h1b, 8'h47);
        u_msc_host_model.wr(8'h1c, 8'h00);
        u_msc_host_model.wr(8'h1e, 8'h34);
        u_msc_host_model.wr(8'h1b, 8'hc7);
        pulse(4'b0001);
        u_msc_host_model.rd(8'h18, v);
        chk({7'h0, v[4]}, 8'h00);
        rc(8'h16, 8'h10);
        rc(8'h1a, 8'h00);
        orient_new = 6'b001000;
        pulse(4'b1000);
        rc(8'h16, 8'h00);
        rc(8'h11, 8'h10);
        motion_active = 1'b1;
        pulse(4'b0010);
        u_msc_host_model.rd(8'h16, v);
        chk({7'h0, v[1]}, 8'h01);
        motion_active = 1'b0;
        repeat (4) @(negedge clk);
        u_msc_host_model.rd(8'h16, v);
        chk({7'h0, v[1]}, 8'h00);
        $display("enables and unlatched motion done");
        u_msc_host_model.wr(8'h1b, 8'h00);
        u_msc_host_model.wr(8'h1d, 8'h5d);
        rc(8'h0c, 8'haa);
        rc(8'h0c, 8'h55);
        rc(8'h1d, 8'h4d);
        u_msc_host_model.wr(8'h1d, 8'hcd);
        chk({7'h0, reboot_busy}, 8'h01);
        u_msc_host_model.rd(8'h1d, v);
        chk({7'h0, v[7]}, 8'h01);
        for (i = 0; i < 400 && reboot_busy === 1'b1; i = i + 1)
            @(negedge clk);
        rc(8'h1d, 8'h4d);
        $display("self-test and reboot done");
        u_msc_host_model.wr(8'h1e, 8'h38);
        u_msc_host_model.wr(8'h1b, 8'h84);
        pulse(4'b0100);
        @(negedge clk) chk({7'h0, irq_out}, 8'h01);
        repeat (12499) @(negedge clk);
        chk({7'h0, irq_out}, 8'h01);
        @(negedge clk) chk({7'h0, irq_out}, 8'h00);
        $display("pulse mode done");
        tally_and_finish;
    end
endmodule
